// file: rtl/asp_map.svh
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

// clock rate and derived bit timing
`define ASP_CLK_HZ      10000000
`define ASP_BAUD_DEF    9600
`define ASP_DIV_DEF     (`ASP_CLK_HZ / `ASP_BAUD_DEF)
`define ASP_MS_NS       1000000
`define ASP_CLK_NS      100
`define ASP_MS_CYC      (`ASP_MS_NS / `ASP_CLK_NS)
`define ASP_TMO_MS_DEF  10000

// register byte offsets
`define ASP_OFS_CTRL    8'h00
`define ASP_OFS_BAUD    8'h04
`define ASP_OFS_TMO     8'h08
`define ASP_OFS_THR     8'h0c
`define ASP_OFS_TXDATA  8'h10
`define ASP_OFS_RXDATA  8'h14
`define ASP_OFS_STATUS  8'h18
`define ASP_OFS_MASK    8'h1c
`define ASP_OFS_LINE    8'h20
`define ASP_OFS_CMD     8'h24

// field positions and reset values
`define ASP_CTRL_W      24
`define ASP_NBITS_DEF   4'h8
`define ASP_STOP_1      5'h0a
`define ASP_STOP_15     5'h0f
`define ASP_STOP_2      5'h14
`define ASP_TERM_LF     8'h0a
`define ASP_TERM_CR     8'h0d
`define ASP_THR_DEF     5'h0c
`define ASP_NF_HYST     5'h04
`define ASP_FIFO_DEPTH  5'h10
`define ASP_XON         8'h11
`define ASP_XOFF        8'h13
`define ASP_CMD_READ    0

// status bits
`define ASP_EV_RDDONE   0
`define ASP_EV_RDTMO    1
`define ASP_EV_WRDONE   2
`define ASP_EV_WRTMO    3
`define ASP_EV_OVR      4
`define ASP_EV_FERR     5
`define ASP_EV_NF       6

`endif

// file: rtl/asp_pkg.sv
// types shared by the serial port modules
package asp_pkg;

  // transmit and receive bit sequencers
  typedef enum logic [2:0] {
    ASP_IDLE  = 3'h0,
    ASP_START = 3'h1,
    ASP_DATA  = 3'h2,
    ASP_PAR   = 3'h3,
    ASP_STOP  = 3'h4
  } asp_bit_e;

  // framing and flow setup, laid out as the control register
  typedef struct packed {
    logic       term_en;
    logic [7:0] term;
    logic [2:0] flow;
    logic [4:0] stop;
    logic [2:0] par;
    logic [3:0] nbits;
  } asp_cfg_s;

  // whole state of the port
  typedef struct packed {
    logic [2:0]  s1;
    logic [2:0]  s2;
    asp_cfg_s    cfg;
    logic [15:0] div;
    logic [15:0] tmo;
    logic [4:0]  thr;
    logic [6:0]  sts;
    logic [6:0]  msk;
    logic        dph;
    logic        wr;
    logic [7:0]  addr;
    logic        hready;
    logic [31:0] hrdata;
    asp_bit_e    tst;
    logic [16:0] tcnt;
    logic [2:0]  tbit;
    logic [7:0]  tsh;
    logic        tpar;
    logic        tflow;
    logic        hold_v;
    logic [7:0]  hold;
    logic        xoff_p;
    logic        xon_p;
    logic        txd;
    logic        rd_busy;
    logic        wr_busy;
    logic [13:0] pre;
    logic [15:0] ms;
    logic        paused;
    logic        nf;
    logic        rts;
    logic        dtr;
    logic        irq;
    asp_bit_e    rst_st;
    logic [16:0] rcnt;
    logic [2:0]  rbit;
    logic [7:0]  rsh;
    logic        rerr;
    logic [3:0]  wp;
    logic [3:0]  rp;
    logic [4:0]  cnt;
  } asp_state_s;

endpackage

// file: rtl/asp_rxmem.sv
// receive buffer storage: sixteen bytes, registered read data
`timescale 1ns/10ps
`default_nettype none

module asp_rxmem
(
  // clock
  input  wire logic       mclk,
  // write side
  input  wire logic       we,
  input  wire logic [3:0] waddr,
  input  wire logic [7:0] wdata,
  // read side
  input  wire logic [3:0] raddr,
  output var  logic [7:0] rdata
);

  // storage array, no reset so it maps to plain ram
  logic [7:0] mem [0:15];

  // write port
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // read port, always follows the head pointer
  always_ff @(posedge mclk)
  begin
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

// file: rtl/asp_port.sv
// serial port with framing, six flow modes, termination and timeouts
// Contract
// - mode 0 ignores all flow control
// - mode 1 sends XOFF, obeys XOFF
// - mode 2 drops RTS, obeys CTS
// - mode 3 sends XOFF and drops RTS, pauses only on XOFF with CTS deasserted
// - mode 4 drops DTR, obeys DSR
// - mode 5 sends XOFF and drops DTR, pauses only on XOFF with DSR deasserted
// - one timeout ends reads and writes
// - read ends on termination character
// - termination recognition can be disabled
// - programmable rate, 9600 baud at reset
// - five to eight data bits, eight default
// - parity none, odd, even, mark, space
// - stop bits one, one and half, two
`timescale 1ns/10ps
`default_nettype none
`include "asp_map.svh"

module asp_port
#(
  parameter int TICK_CYC   = `ASP_MS_CYC,     // clocks per millisecond
  parameter int TMO_MS_DEF = `ASP_TMO_MS_DEF  // timeout at reset, in ms
)
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // serial line
  input  wire logic        rxd,
  output logic             txd,
  // handshake lines, high means asserted
  input  wire logic        cts,
  input  wire logic        dsr,
  output logic             rts,
  output logic             dtr,
  // interrupt
  output logic             irq
);

  asp_pkg::asp_state_s s;     // current state
  asp_pkg::asp_state_s n;     // next state
  logic [7:0]          mem_rd; // head of receive buffer
  logic                mem_we; // store a received byte
  logic [7:0]          mem_wd; // byte to store

  // character width, out of range codes fall back to eight
  function automatic logic [3:0] asp_nb(input logic [3:0] c);
    asp_nb = (c >= 4'h5 && c <= 4'h8) ? c : 4'h8;
  endfunction

  // parity bit for a character of width nb
  function automatic logic asp_par(input logic [7:0] d, input logic [3:0] nb,
                                   input logic [2:0] m);
    logic x;
    x = ^(d & 8'(8'hff >> (4'h8 - nb)));
    case (m)
      3'h1:    asp_par = ~x;
      3'h2:    asp_par = x;
      3'h3:    asp_par = 1'b1;
      default: asp_par = 1'b0;
    endcase
  endfunction

  // stop length in clocks, counted in half bits
  function automatic logic [16:0] asp_stop(input logic [15:0] d, input logic [4:0] c);
    logic [16:0] hv;
    hv = (c == `ASP_STOP_15) ? 17'h3 : (c == `ASP_STOP_2) ? 17'h4 : 17'h2;
    asp_stop = 17'({1'b0, d[15:1]} * hv);
  endfunction

  // line inputs after the second sync stage
  wire logic rxd_s = s.s2[2];
  wire logic cts_s = s.s2[1];
  wire logic dsr_s = s.s2[0];
  wire logic [3:0] nb = asp_nb(s.cfg.nbits);
  // modes that use xon and xoff characters
  wire logic xmode = (s.cfg.flow == 3'h1) || (s.cfg.flow == 3'h3) || (s.cfg.flow == 3'h5);
  // received character aligned to bit zero
  wire logic [7:0] rbyte = 8'(s.rsh >> (4'h8 - nb));
  // bit period less one
  wire logic [16:0] div_m1 = 17'({1'b0, s.div} - 17'h1);

  // transmit suspension per flow mode
  logic susp;
  always_comb
  begin
    case (s.cfg.flow)
      3'h1:    susp = s.paused;
      3'h2:    susp = !cts_s;
      3'h3:    susp = s.paused && !cts_s;
      3'h4:    susp = !dsr_s;
      3'h5:    susp = s.paused && !dsr_s;
      default: susp = 1'b0;
    endcase
  end

  // next state of the whole port
  always_comb
  begin
    logic [6:0] ev;
    logic [6:0] clr;
    logic       push;
    logic       pop;
    ev     = 7'h0;
    clr    = 7'h0;
    push   = 1'b0;
    pop    = 1'b0;
    n      = s;
    mem_we = 1'b0;
    mem_wd = rbyte;
    // two stage synchronisers on pins
    n.s1 = {rxd, cts, dsr};
    n.s2 = s.s1;

    // bus: every transfer takes one wait state
    if (s.dph)
    begin
      n.dph    = 1'b0;
      n.hready = 1'b1;
      n.hrdata = 32'h0;
      if (s.wr)
      begin
        case (s.addr)
          `ASP_OFS_CTRL:   n.cfg = hwdata[`ASP_CTRL_W-1:0];
          `ASP_OFS_BAUD:   n.div = hwdata[15:0];
          `ASP_OFS_TMO:    n.tmo = hwdata[15:0];
          `ASP_OFS_THR:    n.thr = hwdata[4:0];
          `ASP_OFS_MASK:   n.msk = hwdata[6:0];
          `ASP_OFS_TXDATA:
          begin
            // one byte in flight; a write while busy is dropped
            if (!s.hold_v && !s.wr_busy)
            begin
              n.hold_v  = 1'b1;
              n.hold    = hwdata[7:0];
              n.wr_busy = 1'b1;
              n.pre     = 14'h0;
              n.ms      = 16'h0;
            end
          end
          `ASP_OFS_CMD:
          begin
            if (hwdata[`ASP_CMD_READ])
            begin
              n.rd_busy = 1'b1;
              n.pre     = 14'h0;
              n.ms      = 16'h0;
            end
          end
          default: ;
        endcase
      end
      else
      begin
        case (s.addr)
          `ASP_OFS_CTRL:   n.hrdata = {8'h0, s.cfg};
          `ASP_OFS_BAUD:   n.hrdata = {16'h0, s.div};
          `ASP_OFS_TMO:    n.hrdata = {16'h0, s.tmo};
          `ASP_OFS_THR:    n.hrdata = {27'h0, s.thr};
          `ASP_OFS_MASK:   n.hrdata = {25'h0, s.msk};
          `ASP_OFS_RXDATA:
          begin
            n.hrdata = {24'h0, mem_rd};
            pop      = (s.cnt != 5'h0);
          end
          `ASP_OFS_STATUS:
          begin
            // read clears, but a new event in this cycle survives
            n.hrdata = {25'h0, s.sts};
            clr      = s.sts;
          end
          `ASP_OFS_LINE:
          begin
            n.hrdata = {17'h0, (s.tst != asp_pkg::ASP_IDLE), s.hold_v, s.wr_busy,
                        s.rd_busy, dsr_s, cts_s, s.dtr, s.rts, s.paused, s.nf, s.cnt};
          end
          default: n.hrdata = 32'h0;
        endcase
      end
    end
    else if (hsel && htrans[1] && hready)
    begin
      n.dph    = 1'b1;
      n.wr     = hwrite;
      n.addr   = haddr[7:0];
      n.hready = 1'b0;
    end

    // millisecond timer shared by the read and write operations
    if (s.rd_busy || s.wr_busy)
    begin
      if (s.pre == 14'(TICK_CYC - 1))
      begin
        n.pre = 14'h0;
        n.ms  = s.ms + 16'h1;
      end
      else
      begin
        n.pre = s.pre + 14'h1;
      end
      if (s.ms >= s.tmo)
      begin
        if (s.rd_busy)
        begin
          n.rd_busy           = 1'b0;
          ev[`ASP_EV_RDTMO]   = 1'b1;
        end
        if (s.wr_busy)
        begin
          // a byte already on the wire finishes; a held one is dropped
          n.wr_busy           = 1'b0;
          n.hold_v            = 1'b0;
          ev[`ASP_EV_WRTMO]   = 1'b1;
        end
      end
    end

    // nearly full with hysteresis
    if (s.cnt >= s.thr)
    begin
      n.nf = 1'b1;
    end
    else if ({1'b0, s.cnt} + {1'b0, `ASP_NF_HYST} <= {1'b0, s.thr})
    begin
      n.nf = 1'b0;
    end
    if (n.nf && !s.nf)
    begin
      ev[`ASP_EV_NF] = 1'b1;
      if (xmode)
      begin
        n.xoff_p = 1'b1;
        n.xon_p  = 1'b0;
      end
    end
    else if (!n.nf && s.nf && xmode)
    begin
      n.xon_p  = 1'b1;
      n.xoff_p = 1'b0;
    end
    // handshake outputs drop only in their own modes
    n.rts = !(((s.cfg.flow == 3'h2) || (s.cfg.flow == 3'h3)) && s.nf);
    n.dtr = !(((s.cfg.flow == 3'h4) || (s.cfg.flow == 3'h5)) && s.nf);

    // transmitter; flow characters go first and ignore suspension
    if (s.tst == asp_pkg::ASP_IDLE)
    begin
      n.txd = 1'b1;
      if (s.xoff_p || s.xon_p || (s.hold_v && !susp))
      begin
        n.tflow = s.xoff_p || s.xon_p;
        n.tsh   = s.xoff_p ? `ASP_XOFF : s.xon_p ? `ASP_XON : s.hold;
        if (s.xoff_p)
        begin
          n.xoff_p = 1'b0;
        end
        else if (s.xon_p)
        begin
          n.xon_p = 1'b0;
        end
        else
        begin
          n.hold_v = 1'b0;
        end
        n.tpar = asp_par(n.tsh, nb, s.cfg.par);
        n.tst  = asp_pkg::ASP_START;
        n.tcnt = div_m1;
        n.tbit = 3'h0;
        n.txd  = 1'b0;
      end
    end
    else if (s.tcnt != 17'h0)
    begin
      n.tcnt = s.tcnt - 17'h1;
    end
    else
    begin
      n.tcnt = div_m1;
      case (s.tst)
        asp_pkg::ASP_START:
        begin
          n.tst = asp_pkg::ASP_DATA;
          n.txd = s.tsh[0];
        end
        asp_pkg::ASP_DATA:
        begin
          if ({1'b0, s.tbit} == nb - 4'h1)
          begin
            if (s.cfg.par != 3'h0)
            begin
              n.tst = asp_pkg::ASP_PAR;
              n.txd = s.tpar;
            end
            else
            begin
              n.tst  = asp_pkg::ASP_STOP;
              n.txd  = 1'b1;
              n.tcnt = asp_stop(s.div, s.cfg.stop) - 17'h1;
            end
          end
          else
          begin
            n.tbit = s.tbit + 3'h1;
            n.tsh  = s.tsh >> 1;
            n.txd  = s.tsh[1];
          end
        end
        asp_pkg::ASP_PAR:
        begin
          n.tst  = asp_pkg::ASP_STOP;
          n.txd  = 1'b1;
          n.tcnt = asp_stop(s.div, s.cfg.stop) - 17'h1;
        end
        asp_pkg::ASP_STOP:
        begin
          n.tst = asp_pkg::ASP_IDLE;
          if (!s.tflow && s.wr_busy && !n.hold_v)
          begin
            n.wr_busy         = 1'b0;
            ev[`ASP_EV_WRDONE] = 1'b1;
          end
        end
        default: n.tst = asp_pkg::ASP_IDLE;
      endcase
    end

    // receiver, samples mid bit after a half bit start check
    if (s.rst_st == asp_pkg::ASP_IDLE)
    begin
      if (!rxd_s)
      begin
        n.rst_st = asp_pkg::ASP_START;
        n.rcnt   = 17'({2'h0, s.div[15:1]} - 17'h1);
        n.rerr   = 1'b0;
      end
    end
    else if (s.rcnt != 17'h0)
    begin
      n.rcnt = s.rcnt - 17'h1;
    end
    else
    begin
      n.rcnt = div_m1;
      case (s.rst_st)
        asp_pkg::ASP_START:
        begin
          n.rst_st = rxd_s ? asp_pkg::ASP_IDLE : asp_pkg::ASP_DATA;
          n.rbit   = 3'h0;
        end
        asp_pkg::ASP_DATA:
        begin
          n.rsh = {rxd_s, s.rsh[7:1]};
          n.rbit = s.rbit + 3'h1;
          if ({1'b0, s.rbit} == nb - 4'h1)
          begin
            n.rst_st = (s.cfg.par != 3'h0) ? asp_pkg::ASP_PAR : asp_pkg::ASP_STOP;
          end
        end
        asp_pkg::ASP_PAR:
        begin
          n.rerr   = (rxd_s != asp_par(rbyte, nb, s.cfg.par));
          n.rst_st = asp_pkg::ASP_STOP;
        end
        asp_pkg::ASP_STOP:
        begin
          n.rst_st = asp_pkg::ASP_IDLE;
          if (!rxd_s || s.rerr)
          begin
            ev[`ASP_EV_FERR] = 1'b1;   // bad frame is dropped
          end
          else if (xmode && rbyte == `ASP_XOFF)
          begin
            n.paused = 1'b1;
          end
          else if (xmode && rbyte == `ASP_XON)
          begin
            n.paused = 1'b0;
          end
          else
          begin
            if (s.cnt == `ASP_FIFO_DEPTH)
            begin
              ev[`ASP_EV_OVR] = 1'b1;
            end
            else
            begin
              push   = 1'b1;
              mem_we = 1'b1;
            end
            // the terminator itself stays in the buffer
            if (s.rd_busy && s.cfg.term_en && rbyte == s.cfg.term)
            begin
              n.rd_busy          = 1'b0;
              ev[`ASP_EV_RDDONE] = 1'b1;
            end
          end
        end
        default: n.rst_st = asp_pkg::ASP_IDLE;
      endcase
    end

    // buffer pointers
    if (push)
    begin
      n.wp = s.wp + 4'h1;
    end
    if (pop)
    begin
      n.rp = s.rp + 4'h1;
    end
    n.cnt = 5'(s.cnt + {4'h0, push} - {4'h0, pop});
    // sticky status, set wins over the read clear
    n.sts = (s.sts & ~clr) | ev;
    n.irq = |(n.sts & n.msk);
  end

  // state register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s           <= '0;
      s.s1        <= 3'h7;
      s.s2        <= 3'h7;
      s.cfg.nbits <= `ASP_NBITS_DEF;
      s.cfg.stop  <= `ASP_STOP_1;
      s.cfg.term  <= `ASP_TERM_LF;
      s.cfg.term_en <= 1'b1;
      s.div       <= 16'(`ASP_DIV_DEF);
      s.tmo       <= 16'(TMO_MS_DEF);
      s.thr       <= `ASP_THR_DEF;
      s.hready    <= 1'b1;
      s.txd       <= 1'b1;
      s.rts       <= 1'b1;
      s.dtr       <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  // receive buffer storage
  asp_rxmem u_mem (
    .mclk  (mclk),
    .we    (mem_we),
    .waddr (s.wp),
    .wdata (mem_wd),
    .raddr (s.rp),
    .rdata (mem_rd)
  );

  // outputs straight from the state register, hresp tied low
  assign hreadyout = s.hready;
  assign hrdata    = s.hrdata;
  assign hresp     = 1'b0;
  assign txd       = s.txd;
  assign rts       = s.rts;
  assign dtr       = s.dtr;
  assign irq       = s.irq;

  // checks
  a_mode0_lines: assert property (@(posedge mclk) disable iff (rst)
    (s.cfg.flow == 3'h0) |=> (rts && dtr))
    else $error("handshake line dropped in mode 0");
  a_xoff_request: assert property (@(posedge mclk) disable iff (rst)
    (xmode && n.nf && !s.nf) |=> (s.xoff_p || s.tst == asp_pkg::ASP_START))
    else $error("nearly full did not request xoff");
  a_rts_drop: assert property (@(posedge mclk) disable iff (rst)
    (s.cfg.flow == 3'h2 && s.nf) ##1 (s.cfg.flow == 3'h2) |-> !rts)
    else $error("rts not dropped when nearly full");
  a_cts_hold: assert property (@(posedge mclk) disable iff (rst)
    (s.cfg.flow == 3'h2 && !cts_s && s.tst == asp_pkg::ASP_IDLE) |=>
      (s.tst == asp_pkg::ASP_IDLE))
    else $error("transmit started while cts deasserted");
  a_dtr_drop: assert property (@(posedge mclk) disable iff (rst)
    (s.cfg.flow == 3'h4 && s.nf) ##1 (s.cfg.flow == 3'h4) |-> !dtr)
    else $error("dtr not dropped when nearly full");
  a_read_timeout: assert property (@(posedge mclk) disable iff (rst)
    (s.rd_busy && s.ms >= s.tmo) |=> (!s.rd_busy && s.sts[`ASP_EV_RDTMO]))
    else $error("read not ended by timeout");
  a_term_end: assert property (@(posedge mclk) disable iff (rst)
    (s.rd_busy && mem_we && s.cfg.term_en && rbyte == s.cfg.term) |=>
      (!s.rd_busy && s.sts[`ASP_EV_RDDONE]))
    else $error("termination character did not end read");
  a_term_off: assert property (@(posedge mclk) disable iff (rst)
    (!s.cfg.term_en && !s.sts[`ASP_EV_RDDONE]) |=> !s.sts[`ASP_EV_RDDONE])
    else $error("read ended with termination disabled");
  a_reset_frame: assert property (@(posedge mclk)
    $fell(rst) |-> (s.div == 16'(`ASP_DIV_DEF) && s.cfg.nbits == `ASP_NBITS_DEF
                    && s.cfg.stop == `ASP_STOP_1))
    else $error("framing not at defaults after reset");
  a_parity_mark: assert property (@(posedge mclk) disable iff (rst)
    (s.tst == asp_pkg::ASP_PAR && s.cfg.par == 3'h3) |-> txd)
    else $error("mark parity bit not one");
  a_stop_high: assert property (@(posedge mclk) disable iff (rst)
    (s.tst == asp_pkg::ASP_STOP) |-> txd)
    else $error("stop bit not high");
  a_nf_set: assert property (@(posedge mclk) disable iff (rst)
    (s.cnt >= s.thr) |=> s.nf)
    else $error("nearly full not raised at threshold");

endmodule

`default_nettype wire

// file: test/asp_remote.sv
// remote serial station: line frames both ways and handshake levels
`timescale 1ns/10ps
`default_nettype none

module asp_remote
#(
  parameter int BIT_CYC = 16  // clocks per bit, same as the port's divisor
)
(
  // clock
  input  wire logic mclk,
  // serial line and handshakes, high means asserted
  input  wire logic txd,
  output logic      rxd,
  output logic      cts,
  output logic      dsr
);
  // line idles high, handshakes asserted
  initial
  begin
    rxd = 1'h1;
    cts = 1'h1;
    dsr = 1'h1;
  end

  // handshake levels change just after an edge
  task automatic hs(input logic c, input logic d);
    @(posedge mclk);
    cts <= c;
    dsr <= d;
  endtask

  // one 8n1 frame, lsb first; xon and xoff go out this way too
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      rxd <= (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : b[i-1];
      repeat (BIT_CYC - 1) @(posedge mclk);
    end
  endtask

  // frame from the port, sampled mid-bit on falling edges so the
  // register output is settled; the wait for a start bit is bounded
  task automatic recv(input int nb, input bit hp, output logic [7:0] d,
                      output logic p, output logic s);
    int n;
    n = 0;
    d = 8'h00;
    p = 1'h0;
    while (txd !== 1'h0 && n < 4000)
    begin
      @(negedge mclk);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge mclk);
    for (int i = 0; i < nb + hp + 1; i++)
    begin
      repeat (BIT_CYC) @(negedge mclk);
      if (i < nb) d[i] = txd;
      else if (i < nb + hp) p = txd;
      else s = txd;
    end
  endtask
endmodule
`default_nettype wire

// file: test/async_serial_port_with_flow_control_tb.sv
// self-checking bench of the serial port over ahb-lite and a remote station
`timescale 1ns/10ps
`default_nettype none
`include "asp_map.svh"

module async_serial_port_with_flow_control_tb;
  localparam int BC = 16;             // clocks per bit in this run, keeps frames short
  localparam logic [4:0] PX = 5'h0c;  // parity bit of 8'h07 per parity code
  localparam logic [7:0] CT = `ASP_OFS_CTRL, TM = `ASP_OFS_TMO, TX = `ASP_OFS_TXDATA,
                         RX = `ASP_OFS_RXDATA, ST = `ASP_OFS_STATUS, CM = `ASP_OFS_CMD;
  // design ports
  logic        mclk, rst, hsel, hwrite, hreadyout, hresp, rxd, txd, cts, dsr, rts, dtr, irq;
  logic [1:0]  htrans, ef;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  // bench state
  int          error_cnt, num_checks;
  logic [7:0]  d;
  logic        p, s, lo;

  asp_port #(.TICK_CYC(10)) DUT (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxd(rxd), .txd(txd),
    .cts(cts), .dsr(dsr), .rts(rts), .dtr(dtr), .irq(irq));
  asp_remote #(.BIT_CYC(BC)) rem (.mclk(mclk), .txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr));

  // free-running system clock
  initial
  begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  // cut a hang short: the run needs some 10k cycles
  initial
  begin
    #5000000;
    error_cnt++;
    wrap_up();
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    num_checks++;
    if (seen !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // control word, always one stop bit; the two stop bit case flips it with an xor
  function automatic logic [31:0] cf(input logic [3:0] nb, input logic [2:0] pr,
                                     input logic [2:0] fl, input logic [7:0] tc,
                                     input logic te);
    return {8'h00, te, tc, fl, 5'h0a, pr, nb};
  endfunction

  // ready and data are registers, so they are read on the falling edge
  task automatic wt;
    logic rdy;
    do
    begin
      @(negedge mclk);
      rdy = hreadyout;
      r = hrdata;
      @(posedge mclk);
    end
    while (rdy !== 1'h1);
  endtask

  // one single word transfer; read data lands in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    htrans <= 2'h2;
    hsel   <= 1'h1;
    hsize  <= 3'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wt();
    htrans <= 2'h0;
    hsel   <= 1'h0;
    hsize  <= 3'h0;
    hwdata <= v;
    wt();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'h1, a, v);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(nm, r, e);
  endtask

  // byte out through the port, caught at the remote end
  task automatic txf(input logic [7:0] b, input int nb, input bit hp);
    fork
      wr(TX, {24'h000000, b});
      rem.recv(nb, hp, d, p, s);
    join
    repeat (BC) @(posedge mclk);
  endtask

  // main sequence
  initial
  begin
    error_cnt = 0;
    num_checks = 0;
    rst = 1'h1;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'h0;
    hsel = 1'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'h0;
    rd("ctrl", CT, cf(4'h8, 3'h0, 3'h0, 8'h0a, 1'h1));
    rd("baud", `ASP_OFS_BAUD, 32'h411);
    rd("tmo", TM, 32'h2710);
    rd("unmapped", 8'h40, 32'h0);
    wr(`ASP_OFS_BAUD, BC);
    wr(`ASP_OFS_MASK, 32'h4);
    // handshakes down do not matter in mode 0
    rem.hs(1'h0, 1'h0);
    txf(8'h5a, 8, 0);
    chk("mode 0 byte", {d, s}, {8'h5a, 1'h1});
    chk("irq", irq, 1'h1);
    rd("status", ST, 32'h4);
    repeat (2) @(posedge mclk);
    chk("irq clear", irq, 1'h0);
    // two stop bits (code 20 in the stop field): write done comes a full
    // stop bit later than with one, so irq is still low one bit after mid stop
    wr(CT, cf(4'h8, 3'h0, 3'h0, 8'h0a, 1'h1) ^ 32'hf00);
    fork
      wr(TX, 32'h5a);
      rem.recv(8, 0, d, p, s);
    join
    repeat (BC) @(posedge mclk);
    chk("stop 2 early", irq, 1'h0);
    repeat (BC) @(posedge mclk);
    chk("stop 2 end", irq, 1'h1);
    rem.hs(1'h1, 1'h1);
    wr(CT, cf(4'h5, 3'h0, 3'h0, 8'h0a, 1'h1));
    txf(8'h05, 5, 0);
    chk("5 bit char", {d, s}, {8'h05, 1'h1});
    for (int k = 1; k < 5; k++)
    begin
      wr(CT, cf(4'h8, 3'(k), 3'h0, 8'h0a, 1'h1));
      txf(8'h07, 8, 1);
      chk("parity", {d, p}, {8'h07, PX[k]});
    end
    // termination: lf, then cr, then recognition off; read-done stays masked
    wr(CT, cf(4'h8, 3'h0, 3'h0, 8'h0a, 1'h1));
    bus(1'h0, ST, 32'h0);
    wr(CM, 32'h1);
    rem.send(8'h41);
    rem.send(8'h0a);
    chk("irq masked", irq, 1'h0);
    rd("lf end", ST, 32'h1);
    rd("rx 1", RX, 32'h41);
    rd("rx 2", RX, 32'h0a);
    wr(CT, cf(4'h8, 3'h0, 3'h0, 8'h0d, 1'h1));
    wr(CM, 32'h1);
    rem.send(8'h0a);
    rd("no lf end", ST, 32'h0);
    rem.send(8'h0d);
    rd("cr end", ST, 32'h1);
    wr(CT, cf(4'h8, 3'h0, 3'h0, 8'h0d, 1'h0));
    wr(CM, 32'h1);
    rem.send(8'h0d);
    rd("term off", ST, 32'h0);
    wr(TM, 32'h2);
    repeat (40) @(posedge mclk);
    rd("read tmo", ST, 32'h2);
    for (int k = 0; k < 3; k++)
      bus(1'h0, RX, 32'h0);
    wr(TM, 32'h3e8);
    // suspension by xoff, cts and dsr, then resume
    for (int m = 1; m < 5; m += m)
    begin
      wr(CT, cf(4'h8, 3'h0, 3'(m), 8'h0a, 1'h1));
      if (m == 1) rem.send(`ASP_XOFF);
      else rem.hs(m != 2, m != 4);
      wr(TX, 32'h3c);
      lo = 1'h0;
      repeat (100)
      begin
        @(negedge mclk);
        lo = lo | (txd === 1'h0);
      end
      chk("suspended", lo, 1'h0);
      fork
        if (m == 1) rem.send(`ASP_XON);
        else rem.hs(1'h1, 1'h1);
        rem.recv(8, 0, d, p, s);
      join
      chk("resumed", d, 8'h3c);
      repeat (BC) @(posedge mclk);
    end
    // write timeout while dsr holds the byte back; mode 4 is still set
    rem.hs(1'h1, 1'h0);
    bus(1'h0, ST, 32'h0);
    wr(TM, 32'h2);
    wr(TX, 32'h99);
    repeat (40) @(posedge mclk);
    rd("write tmo", ST, 32'h8);
    rem.hs(1'h1, 1'h1);
    wr(TM, 32'h3e8);
    // nearly full at five bytes, released at one, in every flow mode
    wr(`ASP_OFS_THR, 32'h5);
    for (int m = 0; m < 6; m++)
    begin
      ef = {m != 2 && m != 3, m < 4};
      wr(CT, cf(4'h8, 3'h0, 3'(m), 8'h0a, 1'h1));
      wr(CM, 32'h1);
      for (int k = 0; k < 4; k++)
        rem.send(8'h20);
      chk("below thr", {rts, dtr}, 2'h3);
      fork
        rem.send(8'h20);
        if (m % 2 == 1) rem.recv(8, 0, d, p, s);
      join
      repeat (4) @(posedge mclk);
      chk("full lines", {rts, dtr}, ef);
      if (m % 2 == 1) chk("xoff", d, `ASP_XOFF);
      for (int k = 0; k < 3; k++)
        bus(1'h0, RX, 32'h0);
      repeat (3) @(posedge mclk);
      chk("hysteresis", {rts, dtr}, ef);
      fork
        bus(1'h0, RX, 32'h0);
        if (m % 2 == 1) rem.recv(8, 0, d, p, s);
      join
      repeat (3) @(posedge mclk);
      chk("released", {rts, dtr}, 2'h3);
      if (m % 2 == 1) chk("xon", d, `ASP_XON);
      bus(1'h0, RX, 32'h0);
    end
    chk("hresp", hresp, 1'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
